/* logic/mmc_top.sv */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - general input pin can trigger synchronous action
// - pins 4 and 5 feed external drive
// - both parameters reset zero; top bits zero
// - bits 3-0 pick sync pulse polarity
// - bits 6-4 pick sync pulse width
// - bit 7: error disables all sync actions
// - no sync re-enable while error set
// - bits 9-8 pick external drive mode
// - bit 10 picks split pulse polarity
// - bit 11 enables split start pulse
// - step 1 enable and direction
// - step 1 signal select; code 11 invalid
// - step 2 enable and direction
// - step 2 signal: stop 1 or limit
// - step 2 detect may pulse deviation clear
// - step 2 detect may clear counters
// - step 3 enable and direction, stop 2
// - step 3 detect may pulse deviation clear
// - step 3 detect may clear counters
// - step 4 enable, else skipped
module mmc_top #(
    parameter int unsigned SYNC_W6_CYC = mmc_pkg::SYNC_W_CYC[6],
    parameter int unsigned SYNC_W7_CYC = mmc_pkg::SYNC_W_CYC[7]
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] PIO_IN,
    output logic [7:0] PIO_OUT,
    output logic [7:0] PIO_OE_N,
    input wire logic [7:0] DRV_STATUS,
    input wire logic [3:0] CMP_IN,
    input wire logic ERROR_FLAG,
    input wire logic STOP_INPUT_0,
    input wire logic STOP_INPUT_1,
    input wire logic STOP_INPUT_2,
    input wire logic LIMIT_PLUS,
    input wire logic LIMIT_MINUS,
    input wire logic OFFSET_DONE,
    output logic [3:0] SYNC_ACT,
    output logic [1:0] EXT_MODE,
    output logic EXT_PLUS,
    output logic EXT_MINUS,
    output logic SPLIT_POL,
    output logic SPLIT_START,
    output logic [2:0] HOME_STEP,
    output logic HOME_DIR_MINUS,
    output logic HOME_BUSY,
    output logic DEV_CLEAR,
    output logic REAL_POS_CLEAR,
    output logic LOGIC_POS_CLEAR
);
    import mmc_pkg::*;

    function automatic logic [1:0] pin_mode(input logic [15:0] func, input int n);
        pin_mode = func[2*n +: 2];
    endfunction

    function automatic logic [31:0] width_cyc(input logic [2:0] sel);
        case (sel)
            3'h6: width_cyc = SYNC_W6_CYC;
            3'h7: width_cyc = SYNC_W7_CYC;
            default: width_cyc = SYNC_W_CYC[sel];
        endcase
    endfunction

    // two-stage synchronisers for pins
    logic [12:0] meta;
    logic [12:0] syn;
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            meta <= 13'h0000;
            syn <= 13'h0000;
        end else begin
            meta <= {LIMIT_MINUS, LIMIT_PLUS, STOP_INPUT_2, STOP_INPUT_1, STOP_INPUT_0, PIO_IN};
            syn <= meta;
        end
    end
    logic [7:0] pio_s;
    logic stop_input_0_s, stop_input_1_s, stop_input_2_s, lim_p_s, lim_m_s;
    assign pio_s = syn[7:0];
    assign stop_input_0_s = syn[8];
    assign stop_input_1_s = syn[9];
    assign stop_input_2_s = syn[10];
    assign lim_p_s = syn[11];
    assign lim_m_s = syn[12];

    // apb slave and registers
    logic [15:0] pio_cfg, next_pio_cfg;
    logic [15:0] home_cfg, next_home_cfg;
    logic [15:0] pin_func, next_pin_func;
    logic [3:0] sync_en, next_sync_en;
    logic [7:0] gp_out, next_gp_out;
    logic start_req, next_start_req;
    logic abort_req, next_abort_req;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic err_q;
    mmc_home_t home_st;
    logic wr_en;
    logic known;
    logic err_rise;

    assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
    assign err_rise = ERROR_FLAG && !err_q;

    always_comb begin
        known = (PADDR == OFS_PIO_CFG) || (PADDR == OFS_HOME_CFG) || (PADDR == OFS_PIN_FUNC)
            || (PADDR == OFS_SYNC_EN) || (PADDR == OFS_GP_OUT) || (PADDR == OFS_CONTROL)
            || (PADDR == OFS_STATUS);
        next_pready = PSEL && !PENABLE && !PREADY;
        next_pslverr = PSEL && !PENABLE && !known;
        next_prdata = 32'h0000_0000;
        if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                OFS_PIN_FUNC: next_prdata = {16'h0000, pin_func};
                OFS_SYNC_EN: next_prdata = {28'h000_0000, sync_en};
                OFS_GP_OUT: next_prdata = {24'h00_0000, gp_out};
                OFS_STATUS: next_prdata = {24'h00_0000, HOME_BUSY, home_st, ERROR_FLAG, 3'h0};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        next_pio_cfg = pio_cfg;
        next_home_cfg = home_cfg;
        next_pin_func = pin_func;
        next_sync_en = sync_en;
        next_gp_out = gp_out;
        next_start_req = 1'b0;
        next_abort_req = 1'b0;
        if (wr_en && !PSLVERR) begin
            case (PADDR)
                OFS_PIO_CFG: next_pio_cfg = {4'h0, PWDATA[11:0]};
                OFS_HOME_CFG: next_home_cfg = PWDATA[15:0];
                OFS_PIN_FUNC: next_pin_func = PWDATA[15:0];
                OFS_SYNC_EN: begin
                    if (!ERROR_FLAG) begin
                        next_sync_en = PWDATA[3:0];
                    end
                end
                OFS_GP_OUT: next_gp_out = PWDATA[7:0];
                OFS_CONTROL: begin
                    next_start_req = PWDATA[POS_CTL_START];
                    next_abort_req = PWDATA[POS_CTL_ABORT];
                end
                default: ;
            endcase
        end
        // the error wins over a same-cycle enable write
        if (pio_cfg[POS_ERR_DIS] && err_rise) begin
            next_sync_en = 4'h0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pio_cfg <= PIO_CFG_RST;
            home_cfg <= HOME_CFG_RST;
            pin_func <= PIN_FUNC_RST;
            sync_en <= SYNC_EN_RST;
            gp_out <= GP_OUT_RST;
            start_req <= 1'b0;
            abort_req <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            err_q <= 1'b0;
        end else begin
            pio_cfg <= next_pio_cfg;
            home_cfg <= next_home_cfg;
            pin_func <= next_pin_func;
            sync_en <= next_sync_en;
            gp_out <= next_gp_out;
            start_req <= next_start_req;
            abort_req <= next_abort_req;
            PRDATA <= next_prdata;
            PREADY <= next_pready;
            PSLVERR <= next_pslverr;
            err_q <= ERROR_FLAG;
        end
    end

    // synchronous actions: action n fires on a rise of input pin n+4
    logic [7:0] pio_q;
    logic [3:0] next_sync_act;
    logic [31:0] pcnt [4];
    logic [31:0] next_pcnt [4];
    logic [7:0] next_pio_out, next_pio_oe_n;
    logic [3:0] fire;

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            fire[n] = sync_en[n] && pin_mode(pin_func, n + 4) == PIN_GP_IN
                && pio_s[n + 4] && !pio_q[n + 4];
            next_sync_act[n] = fire[n];
            next_pcnt[n] = pcnt[n];
            if (fire[n]) begin
                next_pcnt[n] = width_cyc(pio_cfg[POS_SYNC_WIDTH +: 3]);
            end else if (pcnt[n] != 32'h0000_0000) begin
                next_pcnt[n] = pcnt[n] - 32'h0000_0001;
            end
        end
        for (int n = 0; n < 8; n++) begin
            next_pio_oe_n[n] = 1'b0;
            case (pin_mode(pin_func, n))
                PIN_GP_IN: begin
                    next_pio_oe_n[n] = 1'b1;
                    next_pio_out[n] = 1'b0;
                end
                PIN_GP_OUT: next_pio_out[n] = gp_out[n];
                PIN_DRV_STAT: next_pio_out[n] = DRV_STATUS[n];
                default: begin
                    if (n < 4) begin
                        // pulse is high while counting, inverted for active-low
                        next_pio_out[n] = (next_pcnt[n % 4] != 32'h0000_0000)
                            ^ pio_cfg[POS_SYNC_POL + n % 4];
                    end else begin
                        next_pio_out[n] = CMP_IN[n - 4];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pio_q <= 8'h00;
            SYNC_ACT <= 4'h0;
            PIO_OUT <= 8'h00;
            PIO_OE_N <= 8'hff;
            for (int n = 0; n < 4; n++) begin
                pcnt[n] <= 32'h0000_0000;
            end
        end else begin
            pio_q <= pio_s;
            SYNC_ACT <= next_sync_act;
            PIO_OUT <= next_pio_out;
            PIO_OE_N <= next_pio_oe_n;
            for (int n = 0; n < 4; n++) begin
                pcnt[n] <= next_pcnt[n];
            end
        end
    end

    // external drive and split pulse settings
    logic [1:0] next_ext_mode;
    logic next_ext_plus, next_ext_minus;
    logic ext_ok;

    always_comb begin
        next_ext_mode = pio_cfg[POS_EXT_MODE +: 2];
        ext_ok = next_ext_mode != EXT_OFF;
        next_ext_plus = ext_ok && pin_mode(pin_func, 4) == PIN_GP_IN && pio_s[4];
        next_ext_minus = ext_ok && pin_mode(pin_func, 5) == PIN_GP_IN && pio_s[5];
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            EXT_MODE <= EXT_OFF;
            EXT_PLUS <= 1'b0;
            EXT_MINUS <= 1'b0;
            SPLIT_POL <= 1'b0;
            SPLIT_START <= 1'b0;
        end else begin
            EXT_MODE <= next_ext_mode;
            EXT_PLUS <= next_ext_plus;
            EXT_MINUS <= next_ext_minus;
            SPLIT_POL <= pio_cfg[POS_SPLIT_POL];
            SPLIT_START <= pio_cfg[POS_SPLIT_START];
        end
    end

    // home search sequencer
    function automatic mmc_home_t step_after(input mmc_home_t cur, input logic [15:0] cfg);
        step_after = MMC_IDLE;
        if (cur == MMC_IDLE && cfg[POS_S1_EN]) begin
            step_after = MMC_STEP1;
        end else if ((cur == MMC_IDLE || cur == MMC_STEP1) && cfg[POS_S2_EN]) begin
            step_after = MMC_STEP2;
        end else if (cur != MMC_STEP3 && cur != MMC_STEP4 && cfg[POS_S3_EN]) begin
            step_after = MMC_STEP3;
        end else if (cur != MMC_STEP4 && cfg[POS_S4_EN]) begin
            step_after = MMC_STEP4;
        end
    endfunction

    mmc_home_t next_home_st;
    logic next_busy, next_dir, next_dcc, next_rclr, next_lclr;
    logic s1_hit, s2_hit, s3_hit;
    logic [2:0] next_step_num;

    always_comb begin
        case (home_cfg[POS_S1_SIG +: 2])
            2'b00: s1_hit = stop_input_0_s;
            2'b01: s1_hit = stop_input_1_s;
            2'b10: s1_hit = home_cfg[POS_S1_DIR] ? lim_m_s : lim_p_s;
            default: s1_hit = 1'b0;
        endcase
        if (home_cfg[POS_S2_SIG]) begin
            s2_hit = home_cfg[POS_S2_DIR] ? lim_m_s : lim_p_s;
        end else begin
            s2_hit = stop_input_1_s;
        end
        s3_hit = stop_input_2_s;
        next_home_st = home_st;
        next_dcc = 1'b0;
        next_rclr = 1'b0;
        next_lclr = 1'b0;
        case (home_st)
            MMC_IDLE: begin
                if (start_req) begin
                    next_home_st = step_after(MMC_IDLE, home_cfg);
                end
            end
            MMC_STEP1: begin
                if (s1_hit) begin
                    next_home_st = step_after(MMC_STEP1, home_cfg);
                end
            end
            MMC_STEP2: begin
                if (s2_hit) begin
                    next_home_st = step_after(MMC_STEP2, home_cfg);
                    next_dcc = home_cfg[POS_S2_DCC];
                    next_rclr = home_cfg[POS_S2_RCLR];
                    next_lclr = home_cfg[POS_S2_LCLR];
                end
            end
            MMC_STEP3: begin
                if (s3_hit) begin
                    next_home_st = step_after(MMC_STEP3, home_cfg);
                    next_dcc = home_cfg[POS_S3_DCC];
                    next_rclr = home_cfg[POS_S3_RCLR];
                    next_lclr = home_cfg[POS_S3_LCLR];
                end
            end
            MMC_STEP4: begin
                if (OFFSET_DONE) begin
                    next_home_st = MMC_IDLE;
                end
            end
            default: next_home_st = MMC_IDLE;
        endcase
        if (abort_req) begin
            next_home_st = MMC_IDLE;
        end
        next_busy = next_home_st != MMC_IDLE;
        case (next_home_st)
            MMC_STEP1: begin
                next_step_num = 3'h1;
                next_dir = home_cfg[POS_S1_DIR];
            end
            MMC_STEP2: begin
                next_step_num = 3'h2;
                next_dir = home_cfg[POS_S2_DIR];
            end
            MMC_STEP3: begin
                next_step_num = 3'h3;
                next_dir = home_cfg[POS_S3_DIR];
            end
            MMC_STEP4: begin
                next_step_num = 3'h4;
                next_dir = 1'b0;
            end
            default: begin
                next_step_num = 3'h0;
                next_dir = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            home_st <= MMC_IDLE;
            HOME_BUSY <= 1'b0;
            HOME_STEP <= 3'h0;
            HOME_DIR_MINUS <= 1'b0;
            DEV_CLEAR <= 1'b0;
            REAL_POS_CLEAR <= 1'b0;
            LOGIC_POS_CLEAR <= 1'b0;
        end else begin
            home_st <= next_home_st;
            HOME_BUSY <= next_busy;
            HOME_STEP <= next_step_num;
            HOME_DIR_MINUS <= next_dir;
            DEV_CLEAR <= next_dcc;
            REAL_POS_CLEAR <= next_rclr;
            LOGIC_POS_CLEAR <= next_lclr;
        end
    end

    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    sequence s2_detect;
        home_st == MMC_STEP2 && s2_hit && !abort_req;
    endsequence

    cfg_reset_zero_a: assert property ($past(RESET) |-> pio_cfg == 16'h0000 && home_cfg == 16'h0000)
        else $error("mode parameters not zero after reset");
    err_disable_a: assert property (pio_cfg[POS_ERR_DIS] && err_rise |=> sync_en == 4'h0)
        else $error("sync actions still enabled after error");
    err_block_a: assert property (ERROR_FLAG && !$past(ERROR_FLAG) && !pio_cfg[POS_ERR_DIS] && !wr_en
        |=> sync_en == $past(sync_en))
        else $error("error changed sync enables with disabling off");
    err_reenable_a: assert property (ERROR_FLAG && sync_en == 4'h0 |=> sync_en == 4'h0)
        else $error("sync action enabled while error set");
    sync_width_a: assert property (fire[0] && pio_cfg[6:4] == 3'h1 && pin_mode(pin_func, 0) == PIN_SYNC_CMP
        |=> (PIO_OUT[0] != pio_cfg[0])[*7] ##1 (PIO_OUT[0] == pio_cfg[0] || $past(fire[0])))
        else $error("sync pulse width wrong");
    ext_mode_a: assert property (##1 EXT_MODE == $past(pio_cfg[9:8]))
        else $error("external drive mode not following config");
    split_a: assert property (##1 SPLIT_POL == $past(pio_cfg[10]) && SPLIT_START == $past(pio_cfg[11]))
        else $error("split pulse settings not following config");
    s2_clear_a: assert property (s2_detect |=> DEV_CLEAR == $past(home_cfg[7]) && REAL_POS_CLEAR == $past(home_cfg[8])
        && LOGIC_POS_CLEAR == $past(home_cfg[9]))
        else $error("step 2 detection outputs wrong");
    step_order_a: assert property (home_st == MMC_STEP1 && s1_hit && home_cfg[4] && !abort_req
        |=> home_st == MMC_STEP2)
        else $error("step 2 not entered after step 1");
    skip4_a: assert property (home_st == MMC_STEP3 && s3_hit && !home_cfg[15] |=> home_st == MMC_IDLE)
        else $error("disabled step 4 not skipped");
endmodule // mmc_top

/* logic/mmc_pkg.sv */
package mmc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned NS_PER_S = 1_000_000_000;

    // register byte offsets
    localparam logic [7:0] OFS_PIO_CFG = 8'h00;
    localparam logic [7:0] OFS_HOME_CFG = 8'h04;
    localparam logic [7:0] OFS_PIN_FUNC = 8'h08;
    localparam logic [7:0] OFS_SYNC_EN = 8'h0c;
    localparam logic [7:0] OFS_GP_OUT = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // reset values
    localparam logic [15:0] PIO_CFG_RST = 16'h0000;
    localparam logic [15:0] HOME_CFG_RST = 16'h0000;
    localparam logic [15:0] PIN_FUNC_RST = 16'h0000;
    localparam logic [3:0] SYNC_EN_RST = 4'h0;
    localparam logic [7:0] GP_OUT_RST = 8'h00;

    // pio / external drive config fields
    localparam int POS_SYNC_POL = 0;
    localparam int POS_SYNC_WIDTH = 4;
    localparam int POS_ERR_DIS = 7;
    localparam int POS_EXT_MODE = 8;
    localparam int POS_SPLIT_POL = 10;
    localparam int POS_SPLIT_START = 11;

    // home search config fields
    localparam int POS_S1_EN = 0;
    localparam int POS_S1_DIR = 1;
    localparam int POS_S1_SIG = 2;
    localparam int POS_S2_EN = 4;
    localparam int POS_S2_DIR = 5;
    localparam int POS_S2_SIG = 6;
    localparam int POS_S2_DCC = 7;
    localparam int POS_S2_RCLR = 8;
    localparam int POS_S2_LCLR = 9;
    localparam int POS_S3_EN = 10;
    localparam int POS_S3_DIR = 11;
    localparam int POS_S3_DCC = 12;
    localparam int POS_S3_RCLR = 13;
    localparam int POS_S3_LCLR = 14;
    localparam int POS_S4_EN = 15;

    // control bits
    localparam int POS_CTL_START = 0;
    localparam int POS_CTL_ABORT = 1;

    // pin functions
    localparam logic [1:0] PIN_GP_IN = 2'b00;
    localparam logic [1:0] PIN_GP_OUT = 2'b01;
    localparam logic [1:0] PIN_DRV_STAT = 2'b10;
    localparam logic [1:0] PIN_SYNC_CMP = 2'b11;

    // external drive modes
    localparam logic [1:0] EXT_OFF = 2'b00;

    // synchronous pulse widths in ns, rounded up to cycles
    localparam int unsigned SYNC_W_NS [8] = '{125, 312, 1000, 4000, 16000, 64000, 256000, 1000000};
    localparam int unsigned SYNC_W_CYC [8] = '{
        (SYNC_W_NS[0] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[1] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[2] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[3] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[4] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[5] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[6] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000),
        (SYNC_W_NS[7] * (CLK_HZ / 1000) + NS_PER_S / 1000 - 1) / (NS_PER_S / 1000)};

    typedef enum logic [2:0] {
        MMC_IDLE = 3'b000,
        MMC_STEP1 = 3'b001,
        MMC_STEP2 = 3'b011,
        MMC_STEP3 = 3'b010,
        MMC_STEP4 = 3'b110
    } mmc_home_t;
endpackage

/* verification/mmc_motion_model.sv */
`timescale 1ns/1ps
module mmc_motion_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] step,
    output logic stop_input_0,
    output logic stop_input_1,
    output logic stop_input_2,
    output logic lim_p,
    output logic lim_m,
    output logic off_done
);
    logic [2:0] prev;
    logic [3:0] cnt;
    logic hit;
    assign hit = (cnt == 4'd6);
    always_ff @(posedge clk) begin
        prev <= step;
        cnt <= (rst || step != prev || step == 3'h0) ? 4'd0 : (hit ? cnt : cnt + 4'd1);
    end
    // marker shows a few cycles into a step and drops as soon as the step moves on
    assign stop_input_0 = hit && step == 3'd1;
    assign stop_input_1 = hit && step == 3'd2;
    assign stop_input_2 = hit && step == 3'd3;
    assign off_done = hit && step == 3'd4;
    // limits never reached in these runs
    assign lim_p = 1'b0;
    assign lim_m = 1'b0;
endmodule // mmc_motion_model

/* verification/mmc_top_tb.sv */
`timescale 1ns/1ps
module mmc_top_tb;
    import mmc_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic pen = 0;
    logic pwr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pio_in = 8'h00;
    logic err_flag = 0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, stop_input_0, stop_input_1, stop_input_2, lim_p, lim_m, off_done;
    logic [7:0] pio_out, pio_oe_n;
    logic [3:0] sync_act;
    logic [1:0] ext_mode;
    logic ext_p, ext_m, spl_pol, spl_st, h_dir, h_busy, dev_clr, rp_clr, lp_clr;
    logic [2:0] h_step;
    logic [2:0] last_step = 3'h0;
    logic [15:0] hseq = 16'h0;
    logic [3:0] dseq = 4'h0;
    int bad_count = 0;
    int n_compared = 0;
    int n_sync = 0;
    int n_dev = 0;
    int n_rp = 0;
    int n_lp = 0;
    int i, n, m, base;
    always #25 clk = ~clk;
    mmc_top #(.SYNC_W6_CYC(40), .SYNC_W7_CYC(60)) mmc_top_i (.REF_CLK(clk), .RESET(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PIO_IN(pio_in), .PIO_OUT(pio_out), .PIO_OE_N(pio_oe_n), .DRV_STATUS(8'h00),
        .CMP_IN(4'h0), .ERROR_FLAG(err_flag), .STOP_INPUT_0(stop_input_0), .STOP_INPUT_1(stop_input_1), .STOP_INPUT_2(stop_input_2),
        .LIMIT_PLUS(lim_p), .LIMIT_MINUS(lim_m), .OFFSET_DONE(off_done), .SYNC_ACT(sync_act),
        .EXT_MODE(ext_mode), .EXT_PLUS(ext_p), .EXT_MINUS(ext_m), .SPLIT_POL(spl_pol),
        .SPLIT_START(spl_st), .HOME_STEP(h_step), .HOME_DIR_MINUS(h_dir), .HOME_BUSY(h_busy),
        .DEV_CLEAR(dev_clr), .REAL_POS_CLEAR(rp_clr), .LOGIC_POS_CLEAR(lp_clr));
    mmc_motion_model mmc_motion_model_i (.clk(clk), .rst(rst), .step(h_step), .stop_input_0(stop_input_0),
        .stop_input_1(stop_input_1), .stop_input_2(stop_input_2), .lim_p(lim_p), .lim_m(lim_m), .off_done(off_done));
    always @(posedge clk) begin
        n_sync <= n_sync + (sync_act[0] === 1'b1);
        n_dev <= n_dev + (dev_clr === 1'b1);
        n_rp <= n_rp + (rp_clr === 1'b1);
        n_lp <= n_lp + (lp_clr === 1'b1);
        last_step <= h_step;
        if (h_step !== last_step && h_step !== 3'h0) begin
            hseq <= {hseq[11:0], 1'b0, h_step};
            dseq <= {dseq[2:0], h_dir};
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic timeout();
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // pready is sampled at the rising edge; the request is released at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int j;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (j = 0; j < 20; j++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (j == 20) timeout();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic pulse4();
        @(posedge clk);
        pio_in[4] <= 1'b0;
        cyc(6);
        @(posedge clk);
        pio_in[4] <= 1'b1;
        cyc(8);
    endtask
    task automatic wait_home();
        for (i = 0; i < 40 && h_busy !== 1'b1; i++) cyc(1);
        for (i = 0; i < 600 && h_busy !== 1'b0; i++) cyc(1);
        if (i >= 600) timeout();
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk(pio_oe_n, 8'hff, "oe after reset");
        chk({ext_mode, spl_pol, spl_st, sync_act}, 8'h00, "outputs after reset");
        apb(0, OFS_PIO_CFG, 32'h0);
        chk(rd, 32'h0, "write-only reads zero");
        apb(0, 8'h40, 32'h0);
        chk(er, 1'b1, "unmapped error");
        $display("test reset done");
        apb(1, OFS_PIN_FUNC, 32'h3);
        apb(1, OFS_SYNC_EN, 32'h1);
        apb(1, OFS_PIO_CFG, 32'h11);
        cyc(2);
        chk(pio_out[0], 1'b1, "inverted idle");
        @(posedge clk);
        pio_in[4] <= 1'b1;
        for (i = 0; i < 10 && sync_act[0] !== 1'b1; i++) cyc(1);
        chk(i < 10, 1'b1, "sync fired");
        for (n = 0; n < 40 && pio_out[0] === 1'b0; n++) cyc(1);
        chk(n, 7, "pulse width");
        $display("test sync done");
        apb(1, OFS_PIO_CFG, 32'h80);
        @(posedge clk);
        err_flag <= 1'b1;
        apb(1, OFS_SYNC_EN, 32'h1);
        base = n_sync;
        pulse4();
        chk(n_sync - base, 0, "disabled on error");
        @(posedge clk);
        err_flag <= 1'b0;
        apb(1, OFS_SYNC_EN, 32'h1);
        apb(1, OFS_PIO_CFG, 32'h0);
        @(posedge clk);
        err_flag <= 1'b1;
        base = n_sync;
        pulse4();
        chk(n_sync - base, 1, "kept on error");
        @(posedge clk);
        err_flag <= 1'b0;
        $display("test error done");
        for (m = 0; m < 4; m++) begin
            apb(1, OFS_PIO_CFG, (m << 8) | 32'h400 | ((m & 1) << 11));
            cyc(2);
            chk({ext_mode, spl_pol, spl_st}, {m[1:0], 1'b1, m[0]}, "ext config");
        end
        chk({ext_p, ext_m}, 2'b10, "ext pins");
        $display("test ext done");
        apb(1, OFS_HOME_CFG, 32'hcd93);
        apb(1, OFS_CONTROL, 32'h1);
        wait_home();
        chk(hseq, 16'h1234, "step order");
        chk(dseq[3:1], 3'b101, "step directions");
        chk(n_dev, 1, "deviation clear");
        chk(n_rp, 1, "real clear");
        chk(n_lp, 1, "logic clear");
        apb(1, OFS_HOME_CFG, 32'h0401);
        apb(1, OFS_CONTROL, 32'h1);
        wait_home();
        chk(hseq[7:0], 8'h13, "skipped steps");
        chk(n_dev + n_rp + n_lp, 3, "no clears");
        $display("test home done");
        report_and_stop();
    end
endmodule // mmc_top_tb
